// >>> bench/ild_prog_mem.sv
`timescale 1ns/1ps
module ild_prog_mem (
    input  wire logic        mclk,
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    output logic      [7:0]  mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q;
    logic [7:0] last_d;

    always_comb begin
        last_d = last_q;
        if (mem_rd) begin
            last_d = mem[mem_addr];
        end
    end

    always_ff @(posedge mclk) begin
        last_q <= last_d;
    end

    // Idle cycles return the flipped last byte so sampling them shows up
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
endmodule : ild_prog_mem

// >>> bench/tb_inc_load_opcode_decoder.sv
`timescale 1ns/1ps
module tb_inc_load_opcode_decoder;
    import ild_pkg::*;
    typedef struct {
        logic [7:0]  a;
        logic [7:0]  b;
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] sp;
        logic [15:0] nxt;
        logic [15:0] cyc;
    } ild_exp_t;
    logic        mclk;
    logic        srst;
    logic [7:0]  mem_rdata;
    logic [15:0] mem_addr;
    logic        mem_rd;
    logic [7:0]  acc_a;
    logic [7:0]  acc_b;
    logic [15:0] pointer_x;
    logic [15:0] pointer_y;
    logic [15:0] stack_ptr;
    logic [15:0] prog_ctr;
    logic        instr_done;
    logic        bad_opcode;
    ild_exp_t    exp_q[$];
    ild_exp_t    e;
    logic [7:0]  img [0:65535];
    logic [7:0]  ra;
    logic [7:0]  rb;
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic [15:0] rx;
    logic [15:0] ry;
    logic [15:0] rs;
    logic [15:0] pc;
    logic [15:0] cnt;
    logic [15:0] bad_seen;
    logic [31:0] seed;
    int          failures;
    int          num_checks;

    ild_decoder u_dut (.mclk(mclk), .srst(srst), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .acc_a(acc_a), .acc_b(acc_b), .pointer_x(pointer_x),
        .pointer_y(pointer_y), .stack_ptr(stack_ptr), .prog_ctr(prog_ctr),
        .instr_done(instr_done), .bad_opcode(bad_opcode));
    ild_prog_mem u_mem (.mclk(mclk), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_rdata(mem_rdata));

    function automatic logic [7:0] rnd_byte();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
        return seed[7:0];
    endfunction : rnd_byte

    task automatic emit(input logic [7:0] v);
        img[pc] = v;
        pc = pc + 16'h0001;
    endtask : emit

    task automatic note(input logic [15:0] n);
        exp_q.push_back('{ra, rb, rx, ry, rs, pc, n});
    endtask : note

    task automatic ld_from(input logic [15:0] ea);
        ra = img[ea];
        rb = img[ea + 16'h0001];
    endtask : ld_from

    task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val

    task automatic end_of_test();
        $display("Checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        $display("Error watchdog expected idle queue seen %0d left", exp_q.size());
        end_of_test();
    end

    // Expectations are counted from the first fetch after the previous done pulse to the done pulse
    always @(negedge mclk) begin
        if (srst) begin
            cnt = 16'h0000;
        end else begin
            cnt = cnt + 16'h0001;
            if (bad_opcode === 1'b1) begin
                bad_seen = bad_seen + 16'h0001;
            end
            if (instr_done === 1'b1 && exp_q.size() > 0) begin
                e = exp_q.pop_front();
                check_val("cycles", e.cyc, cnt);
                check_val("acc_a", {8'h00, e.a}, {8'h00, acc_a});
                check_val("acc_b", {8'h00, e.b}, {8'h00, acc_b});
                check_val("pointer_x", e.x, pointer_x);
                check_val("pointer_y", e.y, pointer_y);
                check_val("stack_ptr", e.sp, stack_ptr);
                check_val("next_fetch", e.nxt, mem_addr);
                check_val("bad_opcode", 16'h0000, {15'h0000, bad_opcode});
                cnt = 16'h0000;
            end
        end
    end

    initial begin
        srst = 1'b1;
        seed = 32'h24FE4BB7;
        failures = 0;
        num_checks = 0;
        bad_seen = 16'h0000;
        for (int i = 0; i < 65536; i++) img[i] = rnd_byte();
        pc = 16'h0000;
        rx = 16'h0000;
        ry = 16'h0000;
        rs = 16'h0000;
        emit(OP_LOAD_DOUBLE_IMM);
        emit(8'hFF);
        emit(8'hFE);
        ra = 8'hFF;
        rb = 8'hFE;
        note(16'h0003);
        emit(OP_INCREMENT_ACC_A);
        ra = ra + 8'h01;
        note(16'h0002);
        repeat (2) begin
            emit(OP_INCREMENT_ACC_B);
            rb = rb + 8'h01;
            note(16'h0002);
        end
        // Full byte of increments checks the carry into the upper pointer byte
        repeat (256) begin
            emit(OP_INCREMENT_POINTER);
            rx = rx + 16'h0001;
            note(16'h0003);
            emit(OP_PREFIX_Y);
            emit(OP_INCREMENT_POINTER);
            ry = ry + 16'h0001;
            note(16'h0004);
            emit(OP_INCREMENT_STACK_PTR);
            rs = rs + 16'h0001;
            note(16'h0003);
        end
        repeat (8) begin
            b0 = rnd_byte();
            emit(OP_LOAD_DOUBLE_IND);
            emit(b0);
            ld_from(rx + {8'h00, b0});
            note(16'h0005);
            b0 = rnd_byte();
            emit(OP_PREFIX_Y);
            emit(OP_LOAD_DOUBLE_IND);
            emit(b0);
            ld_from(ry + {8'h00, b0});
            note(16'h0006);
            b0 = rnd_byte();
            emit(OP_LOAD_DOUBLE_DIR);
            emit(b0);
            ld_from({8'h00, b0});
            note(16'h0004);
            // High half kept above the program so later code never alters the data read
            b0 = rnd_byte() | 8'h80;
            b1 = rnd_byte();
            emit(OP_LOAD_DOUBLE_EXT);
            emit(b0);
            emit(b1);
            ld_from({b0, b1});
            note(16'h0005);
            b0 = rnd_byte();
            b1 = rnd_byte();
            emit(OP_LOAD_DOUBLE_IMM);
            emit(b0);
            emit(b1);
            ra = b0;
            rb = b1;
            note(16'h0003);
            emit(OP_INCREMENT_ACC_A);
            ra = ra + 8'h01;
            note(16'h0002);
        end
        // The second byte of a doubled prefix and an unhandled byte are each skipped in one cycle
        emit(OP_PREFIX_Y);
        emit(OP_PREFIX_Y);
        emit(OP_INCREMENT_ACC_B);
        rb = rb + 8'h01;
        note(16'h0004);
        emit(8'h00);
        emit(OP_INCREMENT_ACC_A);
        ra = ra + 8'h01;
        note(16'h0003);
        for (int i = 0; i < 65536; i++) u_mem.mem[i] = img[i];
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        srst <= 1'b0;
        for (int w = 0; w < 16000 && exp_q.size() > 0; w++) @(negedge mclk);
        if (exp_q.size() > 0) begin
            failures++;
            $display("Error done_pulses expected 0 left seen %0d left", exp_q.size());
        end
        check_val("bad_pulses", 16'h0002, bad_seen);
        end_of_test();
    end
endmodule : tb_inc_load_opcode_decoder

// >>> rtl/ild_decoder.sv
`timescale 1ns/1ps
module ild_decoder
    import ild_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic [7:0]  mem_rdata,
    output logic      [15:0] mem_addr,
    output logic             mem_rd,
    output logic      [7:0]  acc_a,
    output logic      [7:0]  acc_b,
    output logic      [15:0] pointer_x,
    output logic      [15:0] pointer_y,
    output logic      [15:0] stack_ptr,
    output logic      [15:0] prog_ctr,
    output logic             instr_done,
    output logic             bad_opcode
);

    // Cycle count of an opcode, fetch included; zero marks an opcode this block does not handle
    function automatic logic [2:0] op_len(input logic [7:0] op, input logic pre);
        logic [2:0] len;
        len = LEN_ILLEGAL;
        unique case (op)
            OP_INCREMENT_ACC_A:     len = pre ? LEN_ILLEGAL : LEN_INC_ACC;
            OP_INCREMENT_ACC_B:     len = pre ? LEN_ILLEGAL : LEN_INC_ACC;
            OP_INCREMENT_STACK_PTR: len = pre ? LEN_ILLEGAL : LEN_INC_16;
            OP_INCREMENT_POINTER:   len = LEN_INC_16;
            OP_LOAD_DOUBLE_IMM:     len = pre ? LEN_ILLEGAL : LEN_LOAD_IMM;
            OP_LOAD_DOUBLE_DIR:     len = pre ? LEN_ILLEGAL : LEN_LOAD_DIR;
            OP_LOAD_DOUBLE_EXT:     len = pre ? LEN_ILLEGAL : LEN_LOAD_EXT;
            OP_LOAD_DOUBLE_IND:     len = LEN_LOAD_IND;
            default:                len = LEN_ILLEGAL;
        endcase
        return len;
    endfunction : op_len

    ild_state_t  st_q,   st_d;
    logic [15:0] pc_q,   pc_d;
    logic [15:0] addr_q, addr_d;
    logic        rd_q,   rd_d;
    logic [7:0]  op_q,   op_d;
    logic        pre_q,  pre_d;
    logic [2:0]  cyc_q,  cyc_d;
    logic [15:0] ea_q,   ea_d;
    logic [7:0]  a_q,    a_d;
    logic [7:0]  b_q,    b_d;
    logic [15:0] x_q,    x_d;
    logic [15:0] y_q,    y_d;
    logic [15:0] sp_q,   sp_d;
    logic        done_q, done_d;
    logic        bad_q,  bad_d;
    logic        finish;

    always_comb begin
        st_d   = st_q;
        pc_d   = pc_q;
        addr_d = addr_q;
        rd_d   = 1'b1;
        op_d   = op_q;
        pre_d  = pre_q;
        cyc_d  = cyc_q;
        ea_d   = ea_q;
        a_d    = a_q;
        b_d    = b_q;
        x_d    = x_q;
        y_d    = y_q;
        sp_d   = sp_q;
        done_d = 1'b0;
        bad_d  = 1'b0;
        finish = 1'b0;
        unique case (st_q)
            ILD_FETCH: begin
                pc_d   = pc_q + ONE_WORD;
                addr_d = pc_q + ONE_WORD;
                if (mem_rdata == OP_PREFIX_Y && !pre_q) begin
                    // Extra fetch cycle for the Y variant
                    pre_d = 1'b1;
                end else if (op_len(mem_rdata, pre_q) == LEN_ILLEGAL) begin
                    // Skipped in one cycle so an unknown byte cannot hang the stream
                    bad_d = 1'b1;
                    pre_d = 1'b0;
                end else begin
                    op_d  = mem_rdata;
                    cyc_d = 3'h1;
                    st_d  = ILD_EXEC;
                end
            end
            ILD_EXEC: begin
                cyc_d = cyc_q + 3'h1;
                unique case (op_q)
                    OP_INCREMENT_ACC_A: begin
                        a_d    = a_q + ONE_BYTE;
                        finish = 1'b1;
                    end
                    OP_INCREMENT_ACC_B: begin
                        b_d    = b_q + ONE_BYTE;
                        finish = 1'b1;
                    end
                    OP_INCREMENT_STACK_PTR, OP_INCREMENT_POINTER: begin
                        // Internal cycle for the 16-bit carry, then write back
                        rd_d = 1'b0;
                        if (cyc_q == LEN_INC_16 - 3'h1) begin
                            finish = 1'b1;
                            if (op_q == OP_INCREMENT_STACK_PTR) begin
                                sp_d = sp_q + ONE_WORD;
                            end else if (pre_q) begin
                                y_d = y_q + ONE_WORD;
                            end else begin
                                x_d = x_q + ONE_WORD;
                            end
                        end
                    end
                    OP_LOAD_DOUBLE_IMM: begin
                        pc_d   = pc_q + ONE_WORD;
                        addr_d = pc_q + ONE_WORD;
                        if (cyc_q == 3'h1) begin
                            a_d = mem_rdata;
                        end else begin
                            b_d    = mem_rdata;
                            finish = 1'b1;
                        end
                    end
                    OP_LOAD_DOUBLE_DIR: begin
                        if (cyc_q == 3'h1) begin
                            pc_d   = pc_q + ONE_WORD;
                            ea_d   = {RESET_BYTE, mem_rdata};
                            addr_d = {RESET_BYTE, mem_rdata};
                        end else if (cyc_q == 3'h2) begin
                            a_d    = mem_rdata;
                            addr_d = ea_q + ONE_WORD;
                        end else begin
                            b_d    = mem_rdata;
                            finish = 1'b1;
                        end
                    end
                    OP_LOAD_DOUBLE_EXT: begin
                        if (cyc_q == 3'h1) begin
                            pc_d   = pc_q + ONE_WORD;
                            addr_d = pc_q + ONE_WORD;
                            ea_d   = {mem_rdata, RESET_BYTE};
                        end else if (cyc_q == 3'h2) begin
                            pc_d   = pc_q + ONE_WORD;
                            ea_d   = {ea_q[15:8], mem_rdata};
                            addr_d = {ea_q[15:8], mem_rdata};
                        end else if (cyc_q == 3'h3) begin
                            a_d    = mem_rdata;
                            addr_d = ea_q + ONE_WORD;
                        end else begin
                            b_d    = mem_rdata;
                            finish = 1'b1;
                        end
                    end
                    OP_LOAD_DOUBLE_IND: begin
                        if (cyc_q == 3'h1) begin
                            // Offset is unsigned; the add is registered here and the bus idles the next cycle
                            pc_d = pc_q + ONE_WORD;
                            ea_d = (pre_q ? y_q : x_q) + {RESET_BYTE, mem_rdata};
                            rd_d = 1'b0;
                        end else if (cyc_q == 3'h2) begin
                            addr_d = ea_q;
                        end else if (cyc_q == 3'h3) begin
                            a_d    = mem_rdata;
                            addr_d = ea_q + ONE_WORD;
                        end else begin
                            b_d    = mem_rdata;
                            finish = 1'b1;
                        end
                    end
                    default: begin
                        finish = 1'b1;
                    end
                endcase
                if (finish) begin
                    st_d   = ILD_FETCH;
                    addr_d = pc_d;
                    rd_d   = 1'b1;
                    pre_d  = 1'b0;
                    cyc_d  = 3'h0;
                    done_d = 1'b1;
                end
            end
            default: begin
                st_d = ILD_FETCH;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_q   <= ILD_FETCH;
            pc_q   <= RESET_PC;
            addr_q <= RESET_PC;
            rd_q   <= 1'b1;
            op_q   <= RESET_BYTE;
            pre_q  <= 1'b0;
            cyc_q  <= 3'h0;
            ea_q   <= RESET_WORD;
            a_q    <= RESET_BYTE;
            b_q    <= RESET_BYTE;
            x_q    <= RESET_WORD;
            y_q    <= RESET_WORD;
            sp_q   <= RESET_WORD;
            done_q <= 1'b0;
            bad_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            pc_q   <= pc_d;
            addr_q <= addr_d;
            rd_q   <= rd_d;
            op_q   <= op_d;
            pre_q  <= pre_d;
            cyc_q  <= cyc_d;
            ea_q   <= ea_d;
            a_q    <= a_d;
            b_q    <= b_d;
            x_q    <= x_d;
            y_q    <= y_d;
            sp_q   <= sp_d;
            done_q <= done_d;
            bad_q  <= bad_d;
        end
    end

    assign mem_addr   = addr_q;
    assign mem_rd     = rd_q;
    assign acc_a      = a_q;
    assign acc_b      = b_q;
    assign pointer_x  = x_q;
    assign pointer_y  = y_q;
    assign stack_ptr  = sp_q;
    assign prog_ctr   = pc_q;
    assign instr_done = done_q;
    assign bad_opcode = bad_q;

    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    sequence fetch_of(logic [7:0] code);
        st_q == ILD_FETCH && !pre_q && mem_rdata == code;
    endsequence

    sequence y_fetch_of(logic [7:0] code);
        fetch_of(OP_PREFIX_Y) ##1 (st_q == ILD_FETCH && mem_rdata == code);
    endsequence

    inc_a_two_a: assert property (fetch_of(OP_INCREMENT_ACC_A) |->
        ##2 (done_q && a_q == $past(a_q, 2) + ONE_BYTE))
        else $error("accumulator A increment wrong or not in 2 cycles");
    inc_b_two_a: assert property (fetch_of(OP_INCREMENT_ACC_B) |->
        ##1 !done_q ##1 (done_q && b_q == $past(b_q, 2) + ONE_BYTE))
        else $error("accumulator B increment wrong or not in 2 cycles");
    inc_x_three_a: assert property (fetch_of(OP_INCREMENT_POINTER) |->
        ##1 !done_q ##1 !done_q ##1 (done_q && x_q == $past(x_q, 3) + ONE_WORD))
        else $error("pointer X increment wrong or not in 3 cycles");
    inc_y_four_a: assert property (y_fetch_of(OP_INCREMENT_POINTER) |->
        ##3 (done_q && y_q == $past(y_q, 3) + ONE_WORD && x_q == $past(x_q, 3)))
        else $error("pointer Y increment wrong or not in 4 cycles");
    load_order_a: assert property (fetch_of(OP_LOAD_DOUBLE_EXT) |->
        ##5 (done_q && a_q == $past(mem_rdata, 2) && b_q == $past(mem_rdata, 1)
             && $past(mem_addr, 1) == $past(mem_addr, 2) + ONE_WORD))
        else $error("double load byte order or address wrong");
    load_imm_a: assert property (fetch_of(OP_LOAD_DOUBLE_IMM) |->
        ##3 (done_q && a_q == $past(mem_rdata, 2) && b_q == $past(mem_rdata, 1)
             && prog_ctr == $past(prog_ctr, 3) + 16'h0003))
        else $error("immediate double load not 3 cycles and 3 bytes");
    load_xidx_a: assert property (fetch_of(OP_LOAD_DOUBLE_IND) |->
        ##4 !done_q ##1 done_q)
        else $error("X-indexed double load not 5 cycles");
    load_yidx_a: assert property (y_fetch_of(OP_LOAD_DOUBLE_IND) |->
        ##4 !done_q ##1 (done_q && a_q == $past(mem_rdata, 2)
             && $past(mem_addr, 2) == y_q + {RESET_BYTE, $past(mem_rdata, 4)}))
        else $error("Y-indexed double load not 6 cycles");
    prefix_step_a: assert property (fetch_of(OP_PREFIX_Y) |=>
        (pre_q && st_q == ILD_FETCH && mem_addr == $past(mem_addr) + ONE_WORD))
        else $error("prefix byte did not add one fetch cycle");

    cov_inc_a_c:  cover property (fetch_of(OP_INCREMENT_ACC_A) ##2 done_q);
    cov_load_iy_c: cover property (y_fetch_of(OP_LOAD_DOUBLE_IND) ##5 done_q);
    cov_back_c:   cover property (done_q ##1 done_q);
    cov_bad_c:    cover property (bad_q);

endmodule : ild_decoder

// >>> rtl/ild_pkg.sv
package ild_pkg;

    typedef enum logic [0:0] {
        ILD_FETCH = 1'b0,
        ILD_EXEC  = 1'b1
    } ild_state_t;

    // Opcode bytes
    localparam logic [7:0] OP_PREFIX_Y            = 8'h18;
    localparam logic [7:0] OP_INCREMENT_ACC_A     = 8'h4C;
    localparam logic [7:0] OP_INCREMENT_ACC_B     = 8'h5C;
    localparam logic [7:0] OP_INCREMENT_STACK_PTR = 8'h31;
    localparam logic [7:0] OP_INCREMENT_POINTER   = 8'h08;
    localparam logic [7:0] OP_LOAD_DOUBLE_IMM     = 8'hCC;
    localparam logic [7:0] OP_LOAD_DOUBLE_DIR     = 8'hDC;
    localparam logic [7:0] OP_LOAD_DOUBLE_EXT     = 8'hFC;
    localparam logic [7:0] OP_LOAD_DOUBLE_IND     = 8'hEC;

    // Bus cycles per instruction, prefix cycle not counted
    localparam logic [2:0] LEN_INC_ACC     = 3'h2;
    localparam logic [2:0] LEN_INC_16      = 3'h3;
    localparam logic [2:0] LEN_LOAD_IMM    = 3'h3;
    localparam logic [2:0] LEN_LOAD_DIR    = 3'h4;
    localparam logic [2:0] LEN_LOAD_EXT    = 3'h5;
    localparam logic [2:0] LEN_LOAD_IND    = 3'h5;
    localparam logic [2:0] LEN_ILLEGAL     = 3'h0;

    // Reset values and increment steps
    localparam logic [15:0] RESET_PC       = 16'h0000;
    localparam logic [15:0] RESET_WORD     = 16'h0000;
    localparam logic [7:0]  RESET_BYTE     = 8'h00;
    localparam logic [15:0] ONE_WORD       = 16'h0001;
    localparam logic [7:0]  ONE_BYTE       = 8'h01;

endpackage : ild_pkg
